// [sgram_command_burst_mode_core.sv]
// command decode, mode register, clock enable and burst core
`default_nettype none
// Function
// - four-beat burst steps column bits 1..0 sequential or interleaved.
// - eight-beat burst steps column bits 2..0 sequential or interleaved.
// - block write column n enables data lines n, 8+n, 16+n, 24+n.
// - all inputs but reset sampled and state advanced on rising clock only; reset clears state asynchronously.
// - clock enable low freezes state and burst address, ignores inputs.
// - clock enable low with both banks idle enters power down.
// - clock enable sampled high ends power down or suspend; commands accepted on that same edge, no early raise needed.
// - bank select latched at activate, read, write, mode, precharge.
// - latch 11-bit row at activate, 8-bit column at read or write.
// - no-operation starts nothing but lets running bursts continue.
// - chip select high disables the command decoder entirely.
// - ready one clock after mode write; outputs stay high impedance.
// - mode write when all strobes and function select low.
// - mode undefined at power-up; rewrite only with banks idle.
// - mode decodes length, type, latency and write burst length.
// - write burst length bit makes every write a single word.
// - full-page burst of 256 columns only with sequential type.
module sgram_command_burst_mode_core (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CKE,
    input wire logic CS_N,
    input wire logic RAS_N,
    input wire logic CAS_N,
    input wire logic WE_N,
    input wire logic GRAPHICS_FUNCTION_SELECT,
    input wire logic BA,
    input wire logic [10:0] ADDR,
    input wire logic [31:0] DQ_IN,
    output logic READY,
    output logic MODE_VALID,
    output logic [2:0] BURST_LEN_CODE,
    output logic BURST_TYPE,
    output logic [2:0] READ_LATENCY,
    output logic SINGLE_WRITE,
    output logic POWER_DOWN,
    output logic SUSPENDED,
    output logic [1:0] BANK_OPEN,
    output logic [10:0] ROW_ADDR,
    output logic LAT_BANK,
    output logic BURST_ACTIVE,
    output logic BURST_WRITE,
    output logic BLOCK_WRITE,
    output logic [7:0] BURST_COL,
    output logic [3:0] BYTE_COL_ENABLE,
    output logic DQ_OE
);
    // state held in one struct
    typedef struct packed {
        sgram_pkg::mode_t mode;
        logic ready;
        logic pd;
        logic susp;
        logic [1:0] open;
        logic [10:0] row;
        logic bank;
        logic active;
        logic wr;
        logic blk;
        logic [7:0] start;
        logic [7:0] beat;
        logic [8:0] beats;
        logic [7:0] col;
        logic [3:0] lane_en;
    } state_t;

    state_t st;
    state_t next_st;
    sgram_pkg::cmd_t cmd;
    logic [7:0] gen_col;
    logic [3:0] pix_en;
    logic sel;
    logic is_act;
    logic is_rd;
    logic is_wr;
    logic is_pre;
    logic is_mrs;
    logic idle;
    logic [8:0] len;
    logic [7:0] next_beat;

    assign cmd = '{cs_n: CS_N, ras_n: RAS_N, cas_n: CAS_N, we_n: WE_N,
                   gfs: GRAPHICS_FUNCTION_SELECT, ba: BA, addr: ADDR};

    // command decode; chip select high masks every strobe
    assign sel = ~cmd.cs_n;
    assign is_act = sel & ~cmd.ras_n & cmd.cas_n & cmd.we_n;
    assign is_rd = sel & cmd.ras_n & ~cmd.cas_n & cmd.we_n;
    assign is_wr = sel & cmd.ras_n & ~cmd.cas_n & ~cmd.we_n;
    assign is_pre = sel & ~cmd.ras_n & cmd.cas_n & ~cmd.we_n;
    assign is_mrs = sel & ~cmd.ras_n & ~cmd.cas_n & ~cmd.we_n
                    & ~cmd.gfs;
    assign idle = (st.open == 2'h0);
    // the column registered next belongs to the following beat
    assign next_beat = 8'(st.beat + 8'h01);

    // beats per burst from the programmed length
    always_comb begin
        unique case (st.mode.bl)
            sgram_pkg::BL_1: len = sgram_pkg::BEATS_1;
            sgram_pkg::BL_2: len = sgram_pkg::BEATS_2;
            sgram_pkg::BL_4: len = sgram_pkg::BEATS_4;
            sgram_pkg::BL_8: len = sgram_pkg::BEATS_8;
            sgram_pkg::BL_FULL: len = sgram_pkg::BEATS_FULL;
            default: len = sgram_pkg::BEATS_1;
        endcase
    end

    burst_addr_gen #(.COL_W(sgram_pkg::COL_W)) u_gen (
        .start_col(st.start),
        .beat(next_beat),
        .bl(st.mode.bl),
        .bt(st.mode.bt),
        .col(gen_col)
    );

    // pixel n of block write takes data line n of every byte lane
    genvar g;
    generate
        for (g = 0; g < sgram_pkg::LANES; g++) begin : g_pix
            assign pix_en[g] =
                DQ_IN[g*sgram_pkg::BYTE_W + int'(ADDR[2:0])];
        end
    endgenerate

    // next-state logic; clock enable low freezes everything but the suspend and power-down flags
    always_comb begin
        next_st = st;
        next_st.susp = ~CKE & ~idle;
        next_st.pd = ~CKE & idle;
        if (CKE) begin
            // running burst advances on any cycle, no-op included
            if (st.active) begin
                if (9'(st.beat) + 9'h001 >= st.beats) begin
                    next_st.active = 1'b0;
                end else begin
                    next_st.beat = next_beat;
                    next_st.col = gen_col;
                end
            end
            if (is_mrs && idle) begin
                next_st.mode.bl = cmd.addr[sgram_pkg::BL_LSB +: 3];
                next_st.mode.bt = cmd.addr[sgram_pkg::BT_BIT];
                next_st.mode.lat = cmd.addr[sgram_pkg::LAT_LSB +: 3];
                next_st.mode.wbl = cmd.addr[sgram_pkg::WBL_BIT];
                // reserved codes leave the mode unusable
                next_st.mode.valid =
                    ((cmd.addr[2:0] == sgram_pkg::BL_1) ||
                     (cmd.addr[2:0] == sgram_pkg::BL_2) ||
                     (cmd.addr[2:0] == sgram_pkg::BL_4) ||
                     (cmd.addr[2:0] == sgram_pkg::BL_8) ||
                     ((cmd.addr[2:0] == sgram_pkg::BL_FULL) &&
                      ~cmd.addr[sgram_pkg::BT_BIT])) &&
                    ((cmd.addr[6:4] == sgram_pkg::LAT_2) ||
                     (cmd.addr[6:4] == sgram_pkg::LAT_3));
                next_st.bank = cmd.ba;
                next_st.ready = 1'b1;
            end
            if (is_act) begin
                next_st.row = cmd.addr;
                next_st.bank = cmd.ba;
                next_st.open[cmd.ba] = 1'b1;
            end
            if (is_pre) begin
                next_st.bank = cmd.ba;
                if (cmd.addr[8]) begin
                    next_st.open = 2'h0;
                end else begin
                    next_st.open[cmd.ba] = 1'b0;
                end
            end
            if ((is_rd || is_wr) && st.mode.valid) begin
                next_st.bank = cmd.ba;
                next_st.start = cmd.addr[7:0];
                next_st.col = cmd.addr[7:0];
                next_st.beat = 8'h00;
                next_st.active = 1'b1;
                next_st.wr = is_wr;
                next_st.blk = is_wr & cmd.gfs;
                next_st.lane_en = (is_wr & cmd.gfs) ? pix_en : 4'hf;
                // block and single-word writes take one beat
                next_st.beats = (is_wr && (st.mode.wbl || cmd.gfs)) ?
                                sgram_pkg::BEATS_1 : len;
            end
        end
    end

    // register the state on the rising edge only
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign READY = st.ready;
    assign MODE_VALID = st.mode.valid;
    assign BURST_LEN_CODE = st.mode.bl;
    assign BURST_TYPE = st.mode.bt;
    assign READ_LATENCY = st.mode.lat;
    assign SINGLE_WRITE = st.mode.wbl;
    assign POWER_DOWN = st.pd;
    assign SUSPENDED = st.susp;
    assign BANK_OPEN = st.open;
    assign ROW_ADDR = st.row;
    assign LAT_BANK = st.bank;
    assign BURST_ACTIVE = st.active;
    assign BURST_WRITE = st.wr;
    assign BLOCK_WRITE = st.blk;
    assign BURST_COL = st.col;
    assign BYTE_COL_ENABLE = st.lane_en;
    // data pins never driven by this core
    assign DQ_OE = 1'b0;

    // assertions
    property p_freeze;
        @(posedge CLK) disable iff (RST)
        !CKE |=> $stable(st.col) && $stable(st.mode);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("cke low moved state");

    property p_pd;
        @(posedge CLK) disable iff (RST)
        (!CKE && st.open == 2'h0) |=> POWER_DOWN;
    endproperty
    a_pd: assert property (p_pd) else $error("no power down");

    property p_act;
        @(posedge CLK) disable iff (RST)
        (CKE && is_act) |=> ROW_ADDR == $past(ADDR) && LAT_BANK == $past(BA);
    endproperty
    a_act: assert property (p_act) else $error("row not latched");

    property p_desel;
        @(posedge CLK) disable iff (RST)
        (CS_N && !st.active) |=> $stable(st.active) && $stable(st.mode);
    endproperty
    a_desel: assert property (p_desel) else $error("deselect acted");

    property p_mrs;
        @(posedge CLK) disable iff (RST)
        (CKE && is_mrs && idle) |=> READY &&
            BURST_LEN_CODE == $past(ADDR[2:0]) &&
            SINGLE_WRITE == $past(ADDR[9]);
    endproperty
    a_mrs: assert property (p_mrs) else $error("mode not written");

    property p_busy_mrs;
        @(posedge CLK) disable iff (RST)
        (is_mrs && !idle) |=> $stable(st.mode);
    endproperty
    a_busy_mrs: assert property (p_busy_mrs)
        else $error("mode while open");

    sequence s_wr1;
        CKE && is_wr && st.mode.valid && st.mode.wbl && !st.active;
    endsequence
    property p_single;
        @(posedge CLK) disable iff (RST)
        s_wr1 ##1 CKE |=> !BURST_ACTIVE;
    endproperty
    a_single: assert property (p_single) else $error("write too long");

    property p_full_seq;
        @(posedge CLK) disable iff (RST)
        (MODE_VALID && BURST_LEN_CODE == sgram_pkg::BL_FULL) |-> !BURST_TYPE;
    endproperty
    a_full_seq: assert property (p_full_seq)
        else $error("full interleave");

    property p_lat;
        @(posedge CLK) disable iff (RST)
        MODE_VALID |-> (READ_LATENCY == 3'h2 || READ_LATENCY == 3'h3);
    endproperty
    a_lat: assert property (p_lat) else $error("bad latency accepted");

    property p_noe;
        @(posedge CLK) disable iff (RST)
        !DQ_OE;
    endproperty
    a_noe: assert property (p_noe) else $error("dq driven");

    property p_rw_latch;
        @(posedge CLK) disable iff (RST)
        (CKE && (is_rd || is_wr) && st.mode.valid) |=> BURST_ACTIVE &&
            LAT_BANK == $past(BA) && BURST_COL == $past(ADDR[7:0]);
    endproperty
    a_rw_latch: assert property (p_rw_latch)
        else $error("read or write not latched");

    property p_nop_run;
        @(posedge CLK) disable iff (RST)
        (CKE && BURST_ACTIVE && !is_rd && !is_wr &&
            (9'(st.beat) + 9'h001 < st.beats)) |=> BURST_ACTIVE;
    endproperty
    a_nop_run: assert property (p_nop_run) else $error("burst cut");

    property p_wake;
        @(posedge CLK) disable iff (RST)
        CKE |=> !POWER_DOWN && !SUSPENDED;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on cke");
endmodule
`default_nettype wire

// [sgram_pkg.sv]
// package of constants and carriers for the graphics dram command core
`default_nettype none
package sgram_pkg;
    localparam int ROW_W = 11;
    localparam int COL_W = 8;
    localparam int MODE_W = 12;
    localparam int DQ_W = 32;
    // mode field positions
    localparam int BL_LSB = 0;
    localparam int BT_BIT = 3;
    localparam int LAT_LSB = 4;
    localparam int WBL_BIT = 9;
    localparam int BA_BIT = 11;
    // burst length codes
    localparam logic [2:0] BL_1 = 3'h0;
    localparam logic [2:0] BL_2 = 3'h1;
    localparam logic [2:0] BL_4 = 3'h2;
    localparam logic [2:0] BL_8 = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    // latency codes
    localparam logic [2:0] LAT_2 = 3'h2;
    localparam logic [2:0] LAT_3 = 3'h3;
    // beats per burst
    localparam logic [8:0] BEATS_1 = 9'h001;
    localparam logic [8:0] BEATS_2 = 9'h002;
    localparam logic [8:0] BEATS_4 = 9'h004;
    localparam logic [8:0] BEATS_8 = 9'h008;
    localparam logic [8:0] BEATS_FULL = 9'h100;
    localparam int BYTE_W = 8;
    localparam int LANES = 4;

    // command pins as sampled
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic gfs;
        logic ba;
        logic [ROW_W-1:0] addr;
    } cmd_t;

    // decoded mode register
    typedef struct packed {
        logic valid;
        logic [2:0] bl;
        logic bt;
        logic [2:0] lat;
        logic wbl;
    } mode_t;
endpackage
`default_nettype wire

// [burst_addr_gen.sv]
// burst column sequencer: sequential or interleave ordering
`default_nettype none
module burst_addr_gen #(
    parameter int COL_W = 8
) (
    input wire logic [COL_W-1:0] start_col,
    input wire logic [COL_W-1:0] beat,
    input wire logic [2:0] bl,
    input wire logic bt,
    output logic [COL_W-1:0] col
);
    // the burst boundaries need at least three column bits
    if (COL_W < 3) begin : g_width_check
        $error("column width too small");
    end

    // low bits wrap inside the burst boundary, upper bits stay fixed
    always_comb begin
        col = start_col;
        unique case (bl)
            sgram_pkg::BL_2: begin
                col[0] = bt ? (start_col[0] ^ beat[0])
                            : (start_col[0] + beat[0]);
            end
            sgram_pkg::BL_4: begin
                col[1:0] = bt ? (start_col[1:0] ^ beat[1:0])
                              : 2'(start_col[1:0] + beat[1:0]);
            end
            sgram_pkg::BL_8: begin
                col[2:0] = bt ? (start_col[2:0] ^ beat[2:0])
                              : 3'(start_col[2:0] + beat[2:0]);
            end
            sgram_pkg::BL_FULL: begin
                col = COL_W'(start_col + beat);
            end
            default: begin
                col = start_col;
            end
        endcase
    end
endmodule
`default_nettype wire

// [mem_ctrl_model.sv]
// controller-side model that turns command requests into pin levels
`default_nettype none
module mem_ctrl_model (
    input wire logic clk,
    input wire sgram_pkg::cmd_t req,
    output var sgram_pkg::cmd_t pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [10:0] last_addr;
    logic mode_cmd;
    // all strobes and function select low marks a mode write
    assign mode_cmd = ~(req.cs_n | req.ras_n | req.cas_n | req.we_n | req.gfs);
    // deselected address pins float, so show the inverse of the last value
    always_comb begin
        pins = req;
        if (req.cs_n) begin
            pins.addr = ~last_addr;
        end
        if (mode_cmd) begin
            pins.addr[10] = 1'b0;
            pins.addr[8:7] = 2'b00;
            pins.ba = 1'b0;
        end
    end
    // remember what the address pins showed last
    always_ff @(posedge clk) begin
        last_addr <= pins.addr;
    end
endmodule
`default_nettype wire

// [sgram_command_burst_mode_core_tb.sv]
// self-checking bench for the graphics dram command core
`default_nettype none
module sgram_command_burst_mode_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [4:0] NOP = 5'h0e, MODE_WRITE_CMD = 5'h00, ACT = 5'h06;
    localparam logic [4:0] RD = 5'h0a, WR = 5'h08, BLK = 5'h09;
    localparam logic [4:0] PRE = 5'h04, REF = 5'h02, DSL = 5'h10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cke = 1'b1;
    logic [31:0] dq = 32'h8421_3c5a;
    sgram_pkg::cmd_t req = {NOP, 12'h000};
    sgram_pkg::cmd_t pins;
    logic ready, mval, bt, sw, pd, susp, lbank, bact, bwr, blk, oe;
    logic [2:0] blc, lat;
    logic [1:0] bopen;
    logic [10:0] row;
    logic [7:0] col, s, ex;
    logic [3:0] ben;
    logic [10:0] modes [8] = '{11'h022, 11'h02a, 11'h033, 11'h03b,
                               11'h037, 11'h03f, 11'h012, 11'h024};
    int errors = 0;
    int compares = 0;
    // free-running system clock
    always #50 clk = ~clk;
    mem_ctrl_model ctrl_u (.clk(clk), .req(req), .pins(pins));
    sgram_command_burst_mode_core dut_u (
        .CLK(clk), .RST(rst), .CKE(cke), .CS_N(pins.cs_n),
        .RAS_N(pins.ras_n), .CAS_N(pins.cas_n), .WE_N(pins.we_n),
        .GRAPHICS_FUNCTION_SELECT(pins.gfs), .BA(pins.ba),
        .ADDR(pins.addr), .DQ_IN(dq), .READY(ready), .MODE_VALID(mval),
        .BURST_LEN_CODE(blc), .BURST_TYPE(bt), .READ_LATENCY(lat),
        .SINGLE_WRITE(sw), .POWER_DOWN(pd), .SUSPENDED(susp),
        .BANK_OPEN(bopen), .ROW_ADDR(row), .LAT_BANK(lbank),
        .BURST_ACTIVE(bact), .BURST_WRITE(bwr), .BLOCK_WRITE(blk),
        .BURST_COL(col), .BYTE_COL_ENABLE(ben), .DQ_OE(oe)
    );
    // compare one value and count the outcome
    task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // present one command for one clock, then let the edge settle
    task automatic step(logic [4:0] op, logic b = 1'b0,
                        logic [10:0] a = 11'h000, logic k = 1'b1);
        @(posedge clk);
        req <= {op, b, a};
        cke <= k;
        #1;
    endtask
    // report counts and the verdict, then end the run
    task automatic stop_test;
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // cut a hang short
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        stop_test;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        // power-up pause of 200 us with no-operation inputs
        repeat (2000) step(NOP);
        chk("ready_early", ready, 0);
        step(PRE, 1'b0, 11'h100);
        step(REF);
        step(REF);
        step(MODE_WRITE_CMD, 1'b0, 11'h222);
        step(NOP);
        chk("bl", blc, 3'h2);
        chk("lat", lat, 3'h2);
        chk("single", sw, 1);
        step(NOP);
        chk("ready", ready, 1);
        chk("dq_oe", oe, 0);
        // single-word write and block-write lane enables
        step(ACT, 1'b0, 11'h0a5);
        step(WR, 1'b0, 11'h003);
        step(NOP);
        chk("wr_act", {bact, bwr}, 2'b11);
        step(NOP);
        chk("wr_end", bact, 0);
        for (int n = 0; n < 8; n++) begin
            step(BLK, 1'b0, 11'(n));
            step(NOP);
            chk("blk", blk, 1);
            chk("ben", ben, {dq[24+n], dq[16+n], dq[8+n], dq[n]});
        end
        // row and bank latch and refused mode write
        step(ACT, 1'b1, 11'h5a3);
        step(NOP);
        chk("row", row, 11'h5a3);
        chk("bank", {lbank, bopen}, 3'b111);
        step(MODE_WRITE_CMD, 1'b0, 11'h033);
        step(NOP);
        chk("mode_busy", blc, 3'h2);
        // suspend in mid-burst freezes the column
        step(RD, 1'b1, 11'h006);
        step(NOP);
        chk("col0", col, 8'h06);
        step(NOP, 1'b0, 11'h000, 1'b0);
        repeat (3) step(RD, 1'b0, 11'h011, 1'b0);
        chk("frozen", col, 8'h07);
        chk("susp", {susp, pd}, 2'b10);
        step(NOP);
        step(NOP);
        chk("resume", susp, 0);
        step(PRE, 1'b0, 11'h100);
        step(DSL, 1'b0, 11'h033);
        step(NOP);
        chk("deselect", blc, 3'h2);
        // power down with both banks idle ignores an activate
        step(NOP, 1'b0, 11'h000, 1'b0);
        step(ACT, 1'b0, 11'h111, 1'b0);
        step(NOP, 1'b0, 11'h000, 1'b0);
        chk("pdown", {pd, bopen}, 3'b100);
        step(NOP);
        step(NOP);
        chk("pd_exit", pd, 0);
        // eight mode codes, then a burst for lengths four and eight
        for (int m = 0; m < 8; m++) begin
            step(MODE_WRITE_CMD, 1'b0, modes[m]);
            step(NOP);
            chk("valid", mval, m < 5);
            chk("fields", {lat, bt, blc}, modes[m][6:0]);
            if (m < 4) begin
                s = 8'hd5;
                step(RD, 1'b0, 11'h0d5);
                for (int i = 0; i < (m < 2 ? 4 : 8); i++) begin
                    step(NOP);
                    ex = 8'(m < 2 ? 3 : 7);
                    ex = (s & ~ex) |
                         ((modes[m][3] ? s ^ 8'(i) : s + 8'(i)) & ex);
                    chk("burst_col", col, ex);
                    chk("burst_on", bact, 1);
                end
                step(NOP);
                chk("burst_off", bact, 0);
            end
        end
        stop_test;
    end
endmodule
`default_nettype wire
